// [src/ssm_consts.vh]
// constants and behaviour summary for the sef defect monitor
// Behaviour
// - declare sef after framing bytes errored in four consecutive frames.
// - declaring sef sets defect status bit 1 to one.
// - each sef change sets interrupt status bit 1 and pulls the interrupt low.
// - while sef declared, clear it after two consecutive error-free frames.
// - clearing sef returns defect status bit 1 to zero.
// - clearing sef raises the same change interrupt as declaring it.
// - defect status byte at index 0x1107 is read-only, bit 1 is sef.
// - interrupt status byte at index 0x110B clears on read, bit 1 is sef change.
`ifndef SSM_CONSTS_VH
`define SSM_CONSTS_VH

// register indices, byte address is four times the index
`define SSM_IDX_DEFECT     16'h1107
`define SSM_IDX_INT_STAT   16'h110B
`define SSM_IDX_INT_EN     16'h1110
`define SSM_IDX_INT_CLR    16'h1111

// field positions
`define SSM_BIT_LOS        0
`define SSM_BIT_SEF        1
`define SSM_BIT_LOF        2

// reset values
`define SSM_RST_INT_EN     8'hFF

// run lengths in frames
`define SSM_ERR_RUN        3'h4
`define SSM_OK_RUN         2'h2

`endif

// [src/ssm_sef_monitor.v]
// sef defect monitor with avalon-mm register slave and interrupt
//
// Chosen here: the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "ssm_consts.vh"

module ssm_sef_monitor (
  // clock and reset
  input  wire        mclk_i,
  input  wire        reset_i,
  // framed receive stream, same clock
  input  wire        frame_sync_i,
  input  wire        frame_err_i,
  // avalon-mm slave
  input  wire [17:0] avs_address_i,
  input  wire        avs_read_i,
  input  wire        avs_write_i,
  input  wire [3:0]  avs_byteenable_i,
  input  wire [31:0] avs_writedata_i,
  output reg  [31:0] avs_readdata_o,
  output wire        avs_waitrequest_o,
  // defect and interrupt
  output wire        sef_o,
  output wire        irq_n_o
);

  localparam [1:0] ST_INFRAME = 2'b01;
  localparam [1:0] ST_SEF     = 2'b10;

  reg  [1:0]  state;
  reg  [1:0]  next_state;
  reg  [2:0]  err_cnt;
  reg  [2:0]  next_err_cnt;
  reg  [1:0]  ok_cnt;
  reg  [1:0]  next_ok_cnt;
  reg         sef_chg;
  reg  [7:0]  int_stat;
  reg  [7:0]  int_en;
  reg         ack;
  reg  [31:0] next_rdata;

  wire        req;
  wire        taken;
  wire        addr_ok;
  wire [15:0] idx;
  wire        sel_defect;
  wire        sel_stat;
  wire        sel_en;
  wire        sel_clr;
  wire [7:0]  defect_byte;
  wire        stat_read;
  wire [7:0]  clr_mask;
  wire [7:0]  set_mask;

  // sef state machine, evaluated once per frame
  always @* begin
    next_state   = state;
    next_err_cnt = err_cnt;
    next_ok_cnt  = ok_cnt;
    case (state)
      ST_INFRAME: begin
        if (frame_sync_i) begin
          if (frame_err_i) begin
            if (err_cnt + 3'h1 == `SSM_ERR_RUN) begin
              next_state   = ST_SEF;
              next_err_cnt = 3'h0;
              next_ok_cnt  = 2'h0;
            end else begin
              next_err_cnt = err_cnt + 3'h1;
            end
          end else begin
            next_err_cnt = 3'h0;
          end
        end
      end
      ST_SEF: begin
        if (frame_sync_i) begin
          if (!frame_err_i) begin
            if (ok_cnt + 2'h1 == `SSM_OK_RUN) begin
              next_state   = ST_INFRAME;
              next_ok_cnt  = 2'h0;
              next_err_cnt = 3'h0;
            end else begin
              next_ok_cnt = ok_cnt + 2'h1;
            end
          end else begin
            next_ok_cnt = 2'h0;
          end
        end
      end
      default: begin
        next_state   = ST_INFRAME;
        next_err_cnt = 3'h0;
        next_ok_cnt  = 2'h0;
      end
    endcase
  end

  always @(posedge mclk_i) begin
    if (reset_i) begin
      state   <= ST_INFRAME;
      err_cnt <= 3'h0;
      ok_cnt  <= 2'h0;
      sef_chg <= 1'b0;
    end else begin
      state   <= next_state;
      err_cnt <= next_err_cnt;
      ok_cnt  <= next_ok_cnt;
      sef_chg <= (next_state != state);
    end
  end

  // defect flag follows the state
  assign sef_o = state[1];

  // bus decode
  assign req        = avs_read_i | avs_write_i;
  assign avs_waitrequest_o = req & ~ack;
  assign taken      = req & ack;
  assign addr_ok    = (avs_address_i[1:0] == 2'b00);
  assign idx        = avs_address_i[17:2];
  assign sel_defect = addr_ok & (idx == `SSM_IDX_DEFECT);
  assign sel_stat   = addr_ok & (idx == `SSM_IDX_INT_STAT);
  assign sel_en     = addr_ok & (idx == `SSM_IDX_INT_EN);
  assign sel_clr    = addr_ok & (idx == `SSM_IDX_INT_CLR);

  // defect byte, only sef is driven here
  assign defect_byte = {6'h00, sef_o, 1'b0};

  // interrupt status set and clear masks, set wins
  // read clears on the capture edge so no event slips between capture and clear
  assign stat_read = req & ~ack & avs_read_i & sel_stat;
  assign clr_mask  = (stat_read ? 8'hFF : 8'h00) |
                     ((taken & avs_write_i & sel_clr & avs_byteenable_i[0]) ? avs_writedata_i[7:0] : 8'h00);
  assign set_mask  = {6'h00, sef_chg, 1'b0};

  always @* begin
    next_rdata = 32'h00000000;
    if (sel_defect) begin
      next_rdata = {24'h000000, defect_byte};
    end else if (sel_stat) begin
      next_rdata = {24'h000000, int_stat};
    end else if (sel_en) begin
      next_rdata = {24'h000000, int_en};
    end
  end

  always @(posedge mclk_i) begin
    if (reset_i) begin
      ack            <= 1'b0;
      avs_readdata_o <= 32'h00000000;
      int_stat       <= 8'h00;
      int_en         <= `SSM_RST_INT_EN;
    end else begin
      ack <= req & ~ack;
      if (req & ~ack & avs_read_i) begin
        avs_readdata_o <= next_rdata;
      end
      int_stat <= (int_stat & ~clr_mask) | set_mask;
      if (taken & avs_write_i & sel_en & avs_byteenable_i[0]) begin
        int_en <= avs_writedata_i[7:0];
      end
    end
  end

  // active-low interrupt while an enabled bit is set
  assign irq_n_o = ~|(int_stat & int_en);

endmodule // ssm_sef_monitor
`default_nettype wire

// [bench/ssm_sef_monitor_assertions.sv]
// sef monitor port checker
`timescale 1ns/1ps
`default_nettype none
module ssm_chk (
  // watched ports
  input wire logic mclk_i, reset_i, frame_sync_i, frame_err_i, avs_read_i,
  input wire logic avs_write_i, avs_waitrequest_o, sef_o, irq_n_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (reset_i);
  wire f = frame_sync_i & frame_err_i;
  wire c = frame_sync_i & !frame_err_i;
  wire r = avs_read_i | avs_write_i;
  AST_SET: assert property ($rose(sef_o) |-> $past(f)) else $error("set");
  AST_CLR: assert property ($fell(sef_o) |-> $past(c)) else $error("clear");
  AST_HOLD0: assert property (c & !sef_o |=> !sef_o) else $error("hold0");
  AST_HOLD1: assert property (f & sef_o |=> sef_o) else $error("hold1");
  AST_IDLE: assert property (!frame_sync_i |=> $stable(sef_o)) else $error("idle");
  AST_IRQ: assert property ($changed(sef_o) |=> !irq_n_o) else $error("irq");
  AST_REL: assert property ($rose(irq_n_o) |-> $past(r)) else $error("release");
  AST_WAIT: assert property ($rose(r) |-> avs_waitrequest_o ##1 !avs_waitrequest_o) else $error("wait");
  cover property ($rose(sef_o));
  cover property ($fell(sef_o));
  cover property ($rose(irq_n_o));
endmodule // ssm_chk
bind ssm_sef_monitor ssm_chk chk_u (.*);
`default_nettype wire

// [bench/ssm_frame_src.sv]
// framed stream source
`timescale 1ns/1ps
`default_nettype none
module ssm_frame_src (
  // clock and frame strobes
  input  wire logic mclk_i,
  output var  logic sync_o,
  output var  logic err_o
);
  initial {sync_o, err_o} = 2'h0;
  task automatic send(input logic e, input int gap);
    repeat (gap + 1) @(posedge mclk_i);
    {sync_o, err_o} <= {1'b1, e};
    @(posedge mclk_i);
    {sync_o, err_o} <= {1'b0, !e};
  endtask
endmodule // ssm_frame_src
`default_nettype wire

// [bench/ssm_sef_monitor_tb.sv]
// sef monitor bench
`timescale 1ns/1ps
`default_nettype none
module ssm_sef_monitor_tb;
  logic clk = 0, rst = 1, rd = 0, wr = 0, m = 0, x, y, fs, fe, sef, irq, wq;
  logic [7:0] wd = 0;
  logic [17:0] ad = 0;
  logic [31:0] q, rdat;
  int n_fail = 0, tests_run = 0, ne = 0, nc = 0, i;
  always #5 clk = ~clk;
  ssm_frame_src src_u (.mclk_i(clk), .sync_o(fs), .err_o(fe));
  ssm_sef_monitor dut_u (.mclk_i(clk), .reset_i(rst), .frame_sync_i(fs), .frame_err_i(fe),
    .avs_address_i(ad), .avs_read_i(rd), .avs_write_i(wr), .avs_byteenable_i(4'hF),
    .avs_writedata_i({24'h0, wd}), .avs_readdata_o(rdat), .avs_waitrequest_o(wq), .sef_o(sef), .irq_n_o(irq));
  task automatic chk(input string n, input logic [31:0] s, v);
    tests_run++;
    if (s !== v) begin
      n_fail++;
      $display("Error %s exp %h got %h", n, v, s);
    end
  endtask
  task automatic bus(input logic w, input logic [17:0] a, input logic [7:0] d);
    @(posedge clk);
    {rd, wr} <= {!w, w};
    {ad, wd} <= {a, d};
    do @(posedge clk); while (wq);
    q = rdat;
    {rd, wr} <= 2'h0;
  endtask
  function automatic logic step(input logic v);
    ne = v ? ne + 1 : 0;
    nc = v ? 0 : nc + 1;
    return ne > 3 | (m & nc < 2);
  endfunction
  task automatic results;
    $display("%0d checks %0d fails", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    i = $urandom(32'hECBB);
    repeat (4) @(posedge clk);
    rst <= 0;
    for (i = 0; i < 40; i++) begin
      x = i < 16 ? 1'(16'hF2F7 >> i) : i < 34 ? 1'($urandom) : i > 35;
      src_u.send(x, $urandom % 3);
      y = step(x);
      #1 chk("sef", sef, y);
      if (y != m && i < 34) begin
        @(posedge clk);
        #1 chk("irq", irq, 0);
        bus(0, 18'h442C, 0);
        chk("stat", q, 2);
        bus(0, 18'h442C, 0);
        chk("rclr", q, 0);
        bus(0, 18'h441C, 0);
        chk("def", q, {y, 1'b0});
      end
      m = y;
    end
    bus(1, 18'h4440, 0);
    #1 chk("mask", irq, 1);
    bus(1, 18'h4444, 2);
    bus(1, 18'h4440, 8'hFF);
    #1 chk("clr", irq, 1);
    bus(0, 18'h4440, 0);
    chk("en", q, 32'hFF);
    bus(0, 18'h442C, 0);
    chk("wclr", q, 0);
    results;
  end
  // run needs under 2000 cycles
  initial begin #100us; n_fail++; results; end
endmodule // ssm_sef_monitor_tb
`default_nettype wire
